//--- logic/rbg_defs.vh
// constants for the repeater bus glue block
`ifndef RBG_DEFS_VH
`define RBG_DEFS_VH

// ----------------------------------------
// clocking
// ----------------------------------------
`define RBG_MCLK_MHZ 100
`define RBG_REF_MHZ 50
`define RBG_MAC_MHZ 25
`define RBG_REF_DIV (`RBG_MCLK_MHZ / `RBG_REF_MHZ)
`define RBG_MAC_DIV (`RBG_REF_MHZ / `RBG_MAC_MHZ)
`define RBG_TICK_DIV (`RBG_REF_DIV * `RBG_MAC_DIV)
`define RBG_PH_LAST 2'h3

// ----------------------------------------
// cycle counter and nibble sequence
// ----------------------------------------
`define RBG_CNT_W 3
`define RBG_CNT_ZERO 3'h0
`define RBG_CNT_MAX 3'h7
`define RBG_CNT_ID_LO 3'h4
`define RBG_CNT_ID_HI 3'h5
`define RBG_CNT_PORT 3'h6
`define RBG_PORT_NUM 4'h0
`define RBG_NIB_ZERO 4'h0
`define RBG_ID_W 5
`define RBG_NIB_W 4

// ----------------------------------------
// data buffer
// ----------------------------------------
`define RBG_FIFO_DEPTH 8
`define RBG_FIFO_AW 3

`endif

//--- logic/rbg_mem.v
// small dual-port memory with registered, write-first read data
module rbg_mem #(
    parameter W = 4,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk_in,
    input wire wr_en_in,
    input wire [AW-1:0] wr_addr_in,
    input wire [W-1:0] wr_data_in,
    input wire [AW-1:0] rd_addr_in,
    output reg [W-1:0] rd_data_out
);
    reg [W-1:0] mem_reg [0:DEPTH-1];

    // bypass so a word written to the address being read is seen at once
    always @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
        if (wr_en_in && (wr_addr_in == rd_addr_in)) begin
            rd_data_out <= wr_data_in;
        end else begin
            rd_data_out <= mem_reg[rd_addr_in];
        end
    end
endmodule // rbg_mem

//--- logic/rbg_fifo.v
// valid/ready fifo around the small memory
module rbg_fifo #(
    parameter W = 4,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire mclk_in,
    input wire rstn_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [W-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [W-1:0] out_data_out
);
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;
    wire [AW-1:0] rd_ptr_next;

    assign in_ready_out = (count_reg != DEPTH[AW:0]);
    assign out_valid_out = (count_reg != {(AW+1){1'b0}});
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    // read address runs one step ahead so the head is ready in its register
    assign rd_ptr_next = pop ? ((rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                : rd_ptr_reg + 1'b1) : rd_ptr_reg;

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                              : wr_ptr_reg + 1'b1;
            end
            rd_ptr_reg <= rd_ptr_next;
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    rbg_mem #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .clk_in(mclk_in),
        .wr_en_in(push),
        .wr_addr_in(wr_ptr_reg),
        .wr_data_in(in_data_in),
        .rd_addr_in(rd_ptr_next),
        .rd_data_out(out_data_out)
    );
endmodule // rbg_fifo

//--- logic/rbg_bridge.v
// mac transmit side posing as one more repeater on the stack bus
`include "rbg_defs.vh"

module rbg_bridge #(
    parameter FIFO_DEPTH = `RBG_FIFO_DEPTH,
    parameter FIFO_AW = `RBG_FIFO_AW
) (
    input wire mclk_in,
    input wire rstn_in,
    input wire [4:0] module_vector_id_in,
    input wire mac_transmit_enable_in,
    input wire [3:0] mac_txd_in,
    output wire mac_clk_out,
    output wire mac_tx_ready_out,
    output reg mac_col_out,
    output reg mac_crs_out,
    output reg [3:0] mac_rxd_out,
    output reg mac_rx_dv_out,
    input wire [3:0] shared_txd_in,
    input wire shared_tx_dv_in,
    input wire [4:0] stack_vector_in,
    output wire [4:0] stack_vector_out,
    output reg [4:0] stack_vector_oe_out,
    output reg vector_match_n_out,
    input wire stack_collision_in_n,
    output reg stack_collision_out_n,
    input wire stack_activity_in_n,
    output reg stack_activity_out_n,
    output reg [3:0] stack_data_out,
    output reg stack_data_oe_out,
    input wire stack_data_ready_in,
    output reg [3:0] mgmt_data_out,
    output reg mgmt_data_oe_out,
    output reg mgmt_frame_valid_n_out,
    output reg fifo_overrun_out
);
    // ----------------------------------------
    // clock division
    // ----------------------------------------
    reg [1:0] phase_reg;
    wire tick;

    // halve mclk to 50 MHz, halve again
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            phase_reg <= 2'h0;
        end else begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    // bit 0 is the 50 MHz reference, bit 1 the 25 MHz mac clock
    assign mac_clk_out = phase_reg[1];
    // counter, nibble, fifo and receive state step once per mac clock, late in its high half
    assign tick = (phase_reg == `RBG_PH_LAST);

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    function vec_equal;
        input [4:0] a;
        input [4:0] b;
        begin
            vec_equal = (a == b);
        end
    endfunction

    function in_nibble_window;
        input [2:0] c;
        begin
            in_nibble_window = c[2] && !(c[1] && c[0]);
        end
    endfunction

    // ----------------------------------------
    // cycle counter
    // ----------------------------------------
    reg [2:0] cnt_reg;
    reg [2:0] cnt_next;
    reg cnt_msb_dly_reg;
    wire mac_transmit_enable;
    wire vect_match;

    assign mac_transmit_enable = mac_transmit_enable_in;
    assign vect_match = vec_equal(stack_vector_in, module_vector_id_in);

    always @* begin
        cnt_next = cnt_reg;
        if (mac_transmit_enable) begin
            if (cnt_reg != `RBG_CNT_MAX) begin
                cnt_next = cnt_reg + 3'h1;
            end
        end else begin
            // step down: 7,6,4,0; top bit lingers to stretch driver enable
            cnt_next = {cnt_reg[1:0], 1'b0};
        end
    end

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_reg <= `RBG_CNT_ZERO;
            cnt_msb_dly_reg <= 1'b0;
        end else if (tick) begin
            cnt_reg <= cnt_next;
            cnt_msb_dly_reg <= cnt_reg[2];
        end
    end

    // ----------------------------------------
    // management nibbles
    // ----------------------------------------
    reg [3:0] md_next;
    reg mdv_n_next;

    always @* begin
        md_next = `RBG_NIB_ZERO;
        mdv_n_next = 1'b1;
        if (mac_transmit_enable) begin
            case (cnt_reg)
                `RBG_CNT_ID_LO: begin
                    md_next = module_vector_id_in[3:0];
                end
                `RBG_CNT_ID_HI: begin
                    md_next = {3'h0, module_vector_id_in[4]};
                end
                `RBG_CNT_PORT: begin
                    md_next = `RBG_PORT_NUM;
                end
                default: begin
                    md_next = `RBG_NIB_ZERO;
                end
            endcase
            // frame valid only for three nibbles
            mdv_n_next = !in_nibble_window(cnt_reg);
        end
    end

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mgmt_data_out <= `RBG_NIB_ZERO;
            mgmt_frame_valid_n_out <= 1'b1;
        end else if (tick) begin
            mgmt_data_out <= md_next;
            mgmt_frame_valid_n_out <= mdv_n_next;
        end
    end

    // ----------------------------------------
    // collision and driver control
    // ----------------------------------------
    wire col_now;
    wire drv_en_now;

    assign col_now = !stack_collision_in_n || (mac_transmit_enable && !vect_match && cnt_reg[2]);
    // enable holds four ticks past enable
    assign drv_en_now = !col_now && (mac_transmit_enable || cnt_msb_dly_reg);

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mac_col_out <= 1'b0;
            stack_collision_out_n <= 1'b1;
            mgmt_data_oe_out <= 1'b0;
            stack_data_oe_out <= 1'b0;
        end else begin
            mac_col_out <= col_now;
            // tell the stack about own mismatch
            stack_collision_out_n <= !(mac_transmit_enable && !vect_match && cnt_reg[2]);
            mgmt_data_oe_out <= drv_en_now;
            stack_data_oe_out <= drv_en_now;
        end
    end

    // ----------------------------------------
    // vector force and compare
    // ----------------------------------------
    // vector lines are wired-low: pull low wherever the identifier bit is zero
    assign stack_vector_out = 5'h00;

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stack_vector_oe_out <= 5'h00;
            vector_match_n_out <= 1'b1;
            stack_activity_out_n <= 1'b1;
            mac_crs_out <= 1'b0;
        end else begin
            stack_vector_oe_out <= mac_transmit_enable ? ~module_vector_id_in : 5'h00;
            vector_match_n_out <= !vect_match;
            stack_activity_out_n <= !mac_transmit_enable;
            // carrier from own send or stack
            mac_crs_out <= mac_transmit_enable || !stack_activity_in_n;
        end
    end

    // ----------------------------------------
    // transmit data path
    // ----------------------------------------
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [3:0] fifo_out_data;
    wire push_req;
    wire pop_req;

    // the mac cannot pause mid-frame; a full buffer is flagged, not hidden
    assign push_req = tick && mac_transmit_enable;
    assign pop_req = tick && stack_data_ready_in;
    assign mac_tx_ready_out = fifo_in_ready;

    // mac nibbles cross to the stack bus
    rbg_fifo #(.W(`RBG_NIB_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .in_valid_in(push_req),
        .in_ready_out(fifo_in_ready),
        .in_data_in(mac_txd_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(pop_req),
        .out_data_out(fifo_out_data)
    );

    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stack_data_out <= `RBG_NIB_ZERO;
            fifo_overrun_out <= 1'b0;
        end else begin
            if (pop_req) begin
                stack_data_out <= fifo_out_valid ? fifo_out_data : `RBG_NIB_ZERO;
            end
            // sticky until reset; a dropped nibble spoils the frame
            if (push_req && !fifo_in_ready) begin
                fifo_overrun_out <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // receive path
    // ----------------------------------------
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mac_rxd_out <= `RBG_NIB_ZERO;
            mac_rx_dv_out <= 1'b0;
        end else if (tick) begin
            // listen on the shared local bus
            mac_rxd_out <= shared_txd_in;
            mac_rx_dv_out <= shared_tx_dv_in;
        end
    end
endmodule // rbg_bridge

//--- testbench/rbg_stack_peer.sv
// other repeaters of the stack, as seen from the bridge pins
module rbg_stack_peer (
    input wire [4:0] own_oe_in,
    input wire [4:0] rival_id_in,
    input wire rival_on_in,
    input wire coll_req_in,
    input wire act_req_in,
    input wire hold_in,
    output wire [4:0] vector_out,
    output wire collision_n_out,
    output wire activity_n_out,
    output wire ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // rival forces its own distinct id
    assign vector_out = ~(own_oe_in | (rival_on_in ? ~rival_id_in : 5'h00));
    // collision and activity from the stack
    assign collision_n_out = !coll_req_in;
    assign activity_n_out = !act_req_in;
    // hold models a slow drain side
    assign ready_out = !hold_in;
endmodule // rbg_stack_peer

//--- testbench/rbg_bridge_properties.sv
// concurrent checks on the bridge ports
module rbg_bridge_properties (
    input wire mclk_in,
    input wire rstn_in,
    input wire [4:0] module_vector_id_in,
    input wire mac_transmit_enable_in,
    input wire mac_clk_out,
    input wire mac_col_out,
    input wire mac_crs_out,
    input wire [4:0] stack_vector_in,
    input wire [4:0] stack_vector_oe_out,
    input wire vector_match_n_out,
    input wire stack_collision_in_n,
    input wire stack_collision_out_n,
    input wire stack_activity_in_n,
    input wire stack_data_oe_out,
    input wire [3:0] mgmt_data_out,
    input wire mgmt_frame_valid_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] low_run_reg;
    // ----------------------------------------
    // frame valid low-run counter
    // ----------------------------------------
    always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            low_run_reg <= 5'h00;
        end else if (mgmt_frame_valid_n_out) begin
            low_run_reg <= 5'h00;
        end else begin
            low_run_reg <= low_run_reg + 5'h01;
        end
    end
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);
    // three ticks of four clocks each
    a_fv_three_ticks: assert property ($rose(mgmt_frame_valid_n_out) |-> low_run_reg == 5'h0c)
        else $error("frame valid low run has wrong length");
    a_mgmt_on_tick: assert property ($changed(mgmt_data_out) |-> $fell(mac_clk_out))
        else $error("management nibble changed off tick");
    a_vector_forced: assert property (mac_transmit_enable_in [*5] |-> stack_vector_oe_out == ~module_vector_id_in)
        else $error("own vector not forced while sending");
    a_vector_idle: assert property ((!mac_transmit_enable_in) [*5] |-> stack_vector_oe_out == 5'h00)
        else $error("vector lines pulled while idle");
    a_match_seen: assert property ((stack_vector_in == module_vector_id_in) [*2] |-> !vector_match_n_out)
        else $error("vector match missing");
    a_mismatch_seen: assert property ((stack_vector_in != module_vector_id_in) [*2] |-> vector_match_n_out)
        else $error("vector match false");
    a_col_from_stack: assert property ((!stack_collision_in_n) [*2] |-> mac_col_out)
        else $error("stack collision not passed to mac");
    a_oe_off_col: assert property (mac_col_out [*2] |-> !stack_data_oe_out)
        else $error("drivers on during collision");
    a_crs_on_tx: assert property (mac_transmit_enable_in [*5] |-> mac_crs_out)
        else $error("carrier sense missing while sending");
    a_crs_on_act: assert property ((!stack_activity_in_n) [*2] |-> mac_crs_out)
        else $error("carrier sense missing on activity");
    a_coll_out_col: assert property (!stack_collision_out_n |-> mac_col_out)
        else $error("stack collision out without mac collision");
endmodule // rbg_bridge_properties

bind rbg_bridge rbg_bridge_properties u_props (.*);

//--- testbench/rbg_bridge_tb.sv
// self-checking bench for the repeater bus glue bridge
module rbg_bridge_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [4:0] id = 5'h00;
    logic en = 1'b0;
    logic [3:0] txd = 4'h0;
    logic [3:0] sh_d = 4'h0;
    logic sh_v = 1'b0;
    logic [4:0] rival_id = 5'h00;
    logic rival_on = 1'b0;
    logic coll_req = 1'b0;
    logic act_req = 1'b0;
    logic hold = 1'b0;
    wire [4:0] vec_in, vec_out, vec_oe;
    wire coll_n, act_n, ready, mclk, tx_rdy, col, crs, rx_dv, match_n, cout_n, aout_n;
    wire [3:0] rxd, sdata, mdata;
    wire soe, moe, fv_n, ovr;
    logic [3:0] q[$];
    int n_errors = 0;
    int num_checks = 0;
    int seed;

    rbg_bridge dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .module_vector_id_in(id),
        .mac_transmit_enable_in(en), .mac_txd_in(txd), .mac_clk_out(mclk),
        .mac_tx_ready_out(tx_rdy), .mac_col_out(col), .mac_crs_out(crs), .mac_rxd_out(rxd),
        .mac_rx_dv_out(rx_dv), .shared_txd_in(sh_d), .shared_tx_dv_in(sh_v),
        .stack_vector_in(vec_in), .stack_vector_out(vec_out), .stack_vector_oe_out(vec_oe),
        .vector_match_n_out(match_n), .stack_collision_in_n(coll_n),
        .stack_collision_out_n(cout_n), .stack_activity_in_n(act_n),
        .stack_activity_out_n(aout_n), .stack_data_out(sdata), .stack_data_oe_out(soe),
        .stack_data_ready_in(ready), .mgmt_data_out(mdata), .mgmt_data_oe_out(moe),
        .mgmt_frame_valid_n_out(fv_n), .fifo_overrun_out(ovr));
    rbg_stack_peer peer (.own_oe_in(vec_oe), .rival_id_in(rival_id), .rival_on_in(rival_on),
        .coll_req_in(coll_req), .act_req_in(act_req), .hold_in(hold), .vector_out(vec_in),
        .collision_n_out(coll_n), .activity_n_out(act_n), .ready_out(ready));

    always #5 mclk_in = ~mclk_in;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // n mac clocks; shared bus copy checked each tick
    task automatic tk(input int n);
        repeat (n) begin
            @(negedge mclk);
            #1;
            chk({3'h0, rx_dv, rxd}, {3'h0, sh_v, sh_d});
            sh_d = 4'($urandom);
            sh_v = 1'($urandom);
        end
    endtask

    task automatic frame(input logic [4:0] fid);
        id = fid;
        en = 1'b1;
        tk(5);
        chk({3'h0, fv_n, mdata}, {4'h0, fid[3:0]});
        tk(1);
        chk({3'h0, fv_n, mdata}, {7'h00, fid[4]});
        tk(1);
        chk({3'h0, fv_n, mdata}, 8'h00);
        tk(1);
        chk({3'h0, fv_n, mdata}, 8'h10);
        chk({4'h0, match_n, col, cout_n, soe}, 8'h03);
        chk({1'h0, vec_out, aout_n, moe}, 8'h01);
        en = 1'b0;
        tk(1);
        chk({7'h00, soe}, 8'h01);
        tk(2);
        chk({7'h00, soe}, 8'h01);
        tk(3);
        chk({6'h00, aout_n, soe}, 8'h02);
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        seed = $urandom(32'h0f4d);
        repeat (10) @(posedge mclk_in);
        #1;
        chk({fv_n, col, tx_rdy, soe, mdata}, 8'ha0);
        rstn_in = 1'b1;
        frame(5'h1f);
        frame(5'h10);
        repeat (4) frame(5'($urandom));
        // rival vector on the lines: mismatch while sending
        id = {4'($urandom), 1'b1};
        rival_id = id ^ 5'h01;
        rival_on = 1'b1;
        en = 1'b1;
        tk(8);
        chk({5'h00, col, cout_n, soe}, 8'h04);
        en = 1'b0;
        rival_on = 1'b0;
        tk(6);
        coll_req = 1'b1;
        act_req = 1'b1;
        tk(1);
        chk({6'h00, col, crs}, 8'h03);
        coll_req = 1'b0;
        act_req = 1'b0;
        tk(2);
        // fill past full with the drain stalled
        hold = 1'b1;
        en = 1'b1;
        for (int i = 0; i < 9; i++) begin
            txd = 4'($urandom);
            if (i < 8) q.push_back(txd);
            tk(1);
        end
        chk({6'h00, tx_rdy, ovr}, 8'h01);
        en = 1'b0;
        tk(1);
        hold = 1'b0;
        for (int i = 0; i < 8; i++) begin
            tk(1);
            chk({4'h0, sdata}, {4'h0, q.pop_front()});
        end
        tk(1);
        chk({2'h0, tx_rdy, ovr, sdata}, 8'h30);
        tk(6);
        frame(5'($urandom));
        wrap_up();
    end

    initial begin
        #300000;
        n_errors++;
        wrap_up();
    end
endmodule // rbg_bridge_tb
